// ==== inc/lbw_pkg.sv ====
`default_nettype none
package lbw_pkg;
    // Timing
    localparam int LBW_BIT_CYCLES = 16;
    localparam logic [3:0] LBW_DATA_BITS = 4'h8;
    localparam logic [3:0] LBW_BREAK_BITS = 4'hc;
    localparam int LBW_WAKE_MIN_BITS = 10;
    localparam int LBW_WAKE_BITS = 13;
    localparam int LBW_WAKE_IDLE_BITS = 4;
    localparam logic [7:0] LBW_SYNC_BYTE = 8'h55;
    // Register offsets
    localparam logic [11:0] LBW_OFF_CTRL = 12'h000;
    localparam logic [11:0] LBW_OFF_STAT = 12'h004;
    localparam logic [11:0] LBW_OFF_TXD = 12'h008;
    localparam logic [11:0] LBW_OFF_RXD = 12'h00c;
    // Control fields
    localparam int LBW_CTRL_TRANSMIT_ENABLE = 0;
    localparam int LBW_CTRL_SEND_BREAK_REQUEST = 1;
    localparam int LBW_CTRL_WUE = 2;
    localparam int LBW_CTRL_ABD = 3;
    localparam logic [3:0] LBW_CTRL_RESET = 4'h0;
    // Status fields
    localparam int LBW_ST_RXF = 0;
    localparam int LBW_ST_FRAMING_ERROR_FLAG = 1;
    localparam int LBW_ST_OVR = 2;
    localparam int LBW_ST_SHIFT_REGISTER_EMPTY = 3;
    localparam int LBW_ST_TXBE = 4;
    localparam int LBW_ST_RXIDL = 5;
    // States
    typedef enum {T_IDLE, T_START, T_DATA, T_STOP} lbw_tx_state_t;
    typedef enum {R_IDLE, R_START, R_DATA, R_STOP, R_WAITHI, R_WAKE} lbw_rx_state_t;
    typedef enum {N_IDLE, N_WAKE, N_GAP, N_START, N_DATA, N_STOP} lbw_node_state_t;
endpackage : lbw_pkg
`default_nettype wire

// ==== inc/lbw_link_if.sv ====
`default_nettype none
interface lbw_link_if;
    // Device to node, node to device
    logic devTx;
    logic nodeTx;
    modport dev (output devTx, input nodeTx);
    modport node (input devTx, output nodeTx);
endinterface : lbw_link_if
`default_nettype wire

// ==== design/lbw_device.sv ====
// Functional notes
// [R1] Far node wake character is all zeros
// [R2] Wake recognised regardless of low duration
// [R3] Non-zero character: first low is wake
// [R4] Far wake character lasts at least 10 bits
// [R5] Far node allows startup time after break
// [R6] Wake event sets receive flag
// [R7] Rising receive line clears wake enable
// [R8] Receive holding read clears receive flag
// [R9] Software checks receive idle before wake enable
// [R10] Break: start, twelve zeros, stop
// [R11] Holding write with send-break starts break
// [R12] Send-break clears after break stop bit
// [R13] Preloaded byte follows break immediately
// [R14] Shift-empty status reports break activity too
// [R15] Header: break, dummy write, then 55h
// [R16] Transmit buffer flag shows holding empty
// [R17] Received break: flag, framing error, 00h
// [R18] Baud rate set before framing detection
// [R19] Wake: two transitions, flag, then data
// [R20] Auto-baud may be enabled before sleep
// [R21] Wake enable disables normal reception
// [R22] Wake flag synchronous in run mode
// [R23] Low stop bit sets framing error
`default_nettype none
module lbw_device
    import lbw_pkg::*;
#(
    parameter int BitCycles = LBW_BIT_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial link
    lbw_link_if.dev link
);
    ////////////////////////////////////////////////////////////////////////
    // APB decode
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic transmit_enable_reg;
    logic sendBreak_reg;
    logic wue_reg;
    logic autoBaud_reg;
    logic holdFull_reg;
    logic holdBreak_reg;
    logic [7:0] holdData_reg;
    logic rxFlag_reg;
    logic framing_error_flag_reg;
    logic ovr_reg;
    logic [7:0] rxHold_reg;
    logic wakeEnd;
    lbw_tx_state_t txState_reg, txState_next;
    lbw_rx_state_t rxState_reg, rxState_next;

    wire setupPh = psel && !penable;
    wire doneAcc = psel && penable && pready_reg;
    wire selCtrl = paddr == LBW_OFF_CTRL;
    wire selStat = paddr == LBW_OFF_STAT;
    wire selTxd = paddr == LBW_OFF_TXD;
    wire selRxd = paddr == LBW_OFF_RXD;
    wire hit = selCtrl || selStat || selTxd || selRxd;
    wire wrCtrl = doneAcc && pwrite && selCtrl;
    wire wrTx = doneAcc && pwrite && selTxd;
    wire rdRx = doneAcc && !pwrite && selRxd;
    wire [5:0] status = {rxState_reg == R_IDLE, !holdFull_reg, txState_reg == T_IDLE,
                         ovr_reg, framing_error_flag_reg, rxFlag_reg}; // R14 R16 R9
    wire [3:0] ctrlRd = {autoBaud_reg, wue_reg, sendBreak_reg, transmit_enable_reg};
    wire [31:0] rdMux = selCtrl ? {28'h0, ctrlRd} :
                        selStat ? {26'h0, status} :
                        selRxd ? {24'h0, rxHold_reg} : 32'h0;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end else begin
            pready_reg <= setupPh;
            pslverr_reg <= setupPh && !hit;
            prdata_reg <= (setupPh && !pwrite) ? rdMux : 32'h0;
        end
    end

    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign prdata = prdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Transmitter
    logic [15:0] txCnt_reg, txCnt_next;
    logic [3:0] txBits_reg, txBits_next;
    logic [7:0] txShift_reg, txShift_next;
    logic shBreak_reg, shBreak_next;
    logic txLine_reg, txLine_next;

    wire txTick = txCnt_reg == 16'(BitCycles - 1);
    wire [15:0] txCntInc = txCnt_reg + 16'h1;
    wire [3:0] txLast = (shBreak_reg ? LBW_BREAK_BITS : LBW_DATA_BITS) - 4'h1; // R10
    wire txLoad = txState_reg == T_IDLE && holdFull_reg; // R13
    wire breakDone = txState_reg == T_STOP && txTick && shBreak_reg;
    wire txWrite = wrTx && transmit_enable_reg && !holdFull_reg;
    wire breakQueued = (holdFull_reg && holdBreak_reg) ||
                       (txState_reg != T_IDLE && shBreak_reg);
    wire sendBreakNext = wrCtrl ? pwdata[LBW_CTRL_SEND_BREAK_REQUEST] :
                         (breakDone ? 1'b0 : sendBreak_reg); // R12

    always_comb begin
        txState_next = txState_reg;
        txCnt_next = txCntInc;
        txBits_next = txBits_reg;
        txShift_next = txShift_reg;
        txLine_next = txLine_reg;
        shBreak_next = shBreak_reg;
        case (txState_reg)
            T_IDLE: begin
                txCnt_next = 16'h0;
                if (txLoad) begin
                    txState_next = T_START;
                    txLine_next = 1'b0;
                    txShift_next = holdBreak_reg ? 8'h00 : holdData_reg; // R11
                    shBreak_next = holdBreak_reg;
                end
            end
            T_START: begin
                if (txTick) begin
                    txState_next = T_DATA;
                    txCnt_next = 16'h0;
                    txBits_next = 4'h0;
                    txLine_next = txShift_reg[0];
                end
            end
            T_DATA: begin
                if (txTick) begin
                    txCnt_next = 16'h0;
                    if (txBits_reg == txLast) begin
                        txState_next = T_STOP;
                        txLine_next = 1'b1;
                    end else begin
                        txBits_next = txBits_reg + 4'h1;
                        txShift_next = {1'b0, txShift_reg[7:1]};
                        txLine_next = txShift_reg[1];
                    end
                end
            end
            T_STOP: begin
                if (txTick) begin
                    txState_next = T_IDLE;
                    txCnt_next = 16'h0;
                end
            end
            default: begin
                txState_next = T_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            txState_reg <= T_IDLE;
            txCnt_reg <= 16'h0;
            txBits_reg <= 4'h0;
            txShift_reg <= 8'h00;
            shBreak_reg <= 1'b0;
            txLine_reg <= 1'b1;
            holdFull_reg <= 1'b0;
            holdBreak_reg <= 1'b0;
            holdData_reg <= 8'h00;
            {autoBaud_reg, wue_reg, sendBreak_reg, transmit_enable_reg} <= LBW_CTRL_RESET;
        end else begin
            txState_reg <= txState_next;
            txCnt_reg <= txCnt_next;
            txBits_reg <= txBits_next;
            txShift_reg <= txShift_next;
            shBreak_reg <= shBreak_next;
            txLine_reg <= txLine_next;
            holdFull_reg <= txWrite || (holdFull_reg && !txLoad); // R16
            if (txWrite) begin
                holdData_reg <= pwdata[7:0];
                holdBreak_reg <= sendBreak_reg && !breakQueued; // R11 R13
            end
            sendBreak_reg <= sendBreakNext;
            if (wrCtrl) begin
                transmit_enable_reg <= pwdata[LBW_CTRL_TRANSMIT_ENABLE];
                autoBaud_reg <= pwdata[LBW_CTRL_ABD];
            end
            wue_reg <= wrCtrl ? pwdata[LBW_CTRL_WUE] : (wakeEnd ? 1'b0 : wue_reg); // R7
        end
    end

    assign link.devTx = txLine_reg;

    ////////////////////////////////////////////////////////////////////////
    // Receiver
    logic rxPrev_reg;
    logic [15:0] rxCnt_reg, rxCnt_next;
    logic [3:0] rxBits_reg, rxBits_next;
    logic [7:0] rxShift_reg, rxShift_next;

    wire rxLine = link.nodeTx;
    wire rxFall = rxPrev_reg && !rxLine;
    wire rxTick = rxCnt_reg == 16'(BitCycles - 1);
    wire rxHalf = rxCnt_reg == 16'(BitCycles / 2 - 1);
    wire [15:0] rxCntInc = rxCnt_reg + 16'h1;
    wire wakeSet = rxState_reg == R_IDLE && wue_reg && rxFall; // R2 R6 R22
    wire rxDone = rxState_reg == R_STOP && rxTick;
    assign wakeEnd = rxState_reg == R_WAKE && rxLine; // R7 R19

    always_comb begin
        rxState_next = rxState_reg;
        rxCnt_next = rxCntInc;
        rxBits_next = rxBits_reg;
        rxShift_next = rxShift_reg;
        case (rxState_reg)
            R_IDLE: begin
                rxCnt_next = 16'h0;
                if (rxFall) begin
                    rxState_next = wue_reg ? R_WAKE : R_START; // R21
                end
            end
            R_START: begin
                if (rxHalf) begin
                    rxState_next = rxLine ? R_IDLE : R_DATA;
                    rxCnt_next = 16'h0;
                    rxBits_next = 4'h0;
                end
            end
            R_DATA: begin
                if (rxTick) begin
                    rxCnt_next = 16'h0;
                    rxShift_next = {rxLine, rxShift_reg[7:1]};
                    rxBits_next = rxBits_reg + 4'h1;
                    if (rxBits_reg == LBW_DATA_BITS - 4'h1) begin
                        rxState_next = R_STOP;
                    end
                end
            end
            R_STOP: begin
                if (rxTick) begin
                    rxState_next = rxLine ? R_IDLE : R_WAITHI;
                end
            end
            R_WAITHI: begin
                if (rxLine) begin
                    rxState_next = R_IDLE;
                end
            end
            R_WAKE: begin
                rxCnt_next = 16'h0;
                if (rxLine) begin
                    rxState_next = R_IDLE; // R3
                end
            end
            default: begin
                rxState_next = R_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rxState_reg <= R_IDLE;
            rxPrev_reg <= 1'b1;
            rxCnt_reg <= 16'h0;
            rxBits_reg <= 4'h0;
            rxShift_reg <= 8'h00;
            rxHold_reg <= 8'h00;
            rxFlag_reg <= 1'b0;
            framing_error_flag_reg <= 1'b0;
            ovr_reg <= 1'b0;
        end else begin
            rxState_reg <= rxState_next;
            rxPrev_reg <= rxLine;
            rxCnt_reg <= rxCnt_next;
            rxBits_reg <= rxBits_next;
            rxShift_reg <= rxShift_next;
            if (rxDone) begin
                rxHold_reg <= rxShift_reg; // R17
            end else if (wakeSet) begin
                rxHold_reg <= 8'h00;
            end
            rxFlag_reg <= rxDone || wakeSet || (rxFlag_reg && !rdRx); // R6 R8
            framing_error_flag_reg <= rxDone ? !rxLine : (framing_error_flag_reg && !rdRx); // R23 R17
            ovr_reg <= (rxDone && rxFlag_reg && !rdRx) || (ovr_reg && !rdRx);
        end
    end
endmodule : lbw_device
`default_nettype wire

// ==== design/lbw_node.sv ====
`default_nettype none
module lbw_node
    import lbw_pkg::*;
#(
    parameter int BitCycles = LBW_BIT_CYCLES,
    parameter int WakeBits = LBW_WAKE_BITS,
    parameter int IdleBits = LBW_WAKE_IDLE_BITS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // User requests
    input wire logic wakeReq,
    input wire logic headerReq,
    input wire logic byteReq,
    input wire logic [7:0] byteData,
    output logic busy,
    // User receive
    output logic rxValid,
    output logic [7:0] rxData,
    output logic rxBreak,
    // Serial link
    lbw_link_if.node link
);
    ////////////////////////////////////////////////////////////////////////
    // Transmitter
    localparam int WakeEff = (WakeBits < LBW_WAKE_MIN_BITS) ? LBW_WAKE_MIN_BITS : WakeBits;

    lbw_node_state_t st_reg, st_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [7:0] bits_reg, bits_next;
    logic [7:0] shift_reg, shift_next;
    logic line_reg, line_next;
    logic sync_reg, sync_next;

    wire tick = cnt_reg == 16'(BitCycles - 1); // R18
    wire [15:0] cntInc = cnt_reg + 16'h1;
    wire [7:0] bitsInc = bits_reg + 8'h1;

    always_comb begin
        st_next = st_reg;
        cnt_next = cntInc;
        bits_next = bits_reg;
        shift_next = shift_reg;
        line_next = line_reg;
        sync_next = sync_reg;
        case (st_reg)
            N_IDLE: begin
                cnt_next = 16'h0;
                bits_next = 8'h0;
                if (wakeReq || headerReq) begin
                    st_next = N_WAKE;
                    line_next = 1'b0; // R1
                    sync_next = headerReq;
                end else if (byteReq) begin
                    st_next = N_START;
                    line_next = 1'b0;
                    shift_next = byteData;
                end
            end
            N_WAKE: begin
                if (tick) begin
                    cnt_next = 16'h0;
                    bits_next = bitsInc;
                    if (bitsInc == 8'(WakeEff)) begin // R4
                        st_next = N_GAP;
                        bits_next = 8'h0;
                        line_next = 1'b1;
                    end
                end
            end
            N_GAP: begin
                if (tick) begin
                    cnt_next = 16'h0;
                    bits_next = bitsInc;
                    if (bitsInc == 8'(IdleBits)) begin // R5
                        st_next = sync_reg ? N_START : N_IDLE;
                        line_next = !sync_reg;
                        shift_next = LBW_SYNC_BYTE; // R15
                        sync_next = 1'b0;
                    end
                end
            end
            N_START: begin
                if (tick) begin
                    st_next = N_DATA;
                    cnt_next = 16'h0;
                    bits_next = 8'h0;
                    line_next = shift_reg[0];
                end
            end
            N_DATA: begin
                if (tick) begin
                    cnt_next = 16'h0;
                    if (bits_reg == 8'(LBW_DATA_BITS) - 8'h1) begin
                        st_next = N_STOP;
                        line_next = 1'b1;
                    end else begin
                        bits_next = bitsInc;
                        shift_next = {1'b0, shift_reg[7:1]};
                        line_next = shift_reg[1];
                    end
                end
            end
            N_STOP: begin
                if (tick) begin
                    st_next = N_IDLE;
                    cnt_next = 16'h0;
                end
            end
            default: begin
                st_next = N_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_reg <= N_IDLE;
            cnt_reg <= 16'h0;
            bits_reg <= 8'h0;
            shift_reg <= 8'h00;
            line_reg <= 1'b1;
            sync_reg <= 1'b0;
            busy <= 1'b0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            bits_reg <= bits_next;
            shift_reg <= shift_next;
            line_reg <= line_next;
            sync_reg <= sync_next;
            busy <= st_next != N_IDLE;
        end
    end

    assign link.nodeTx = line_reg;

    ////////////////////////////////////////////////////////////////////////
    // Receiver
    lbw_rx_state_t rs_reg;
    logic prev_reg;
    logic [15:0] rc_reg;
    logic [3:0] rb_reg;
    logic [7:0] rsh_reg;

    wire rxLine = link.devTx;
    wire rTick = rc_reg == 16'(BitCycles - 1);
    wire rHalf = rc_reg == 16'(BitCycles / 2 - 1);
    wire [15:0] rcInc = rc_reg + 16'h1;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rs_reg <= R_IDLE;
            prev_reg <= 1'b1;
            rc_reg <= 16'h0;
            rb_reg <= 4'h0;
            rsh_reg <= 8'h00;
            rxValid <= 1'b0;
            rxData <= 8'h00;
            rxBreak <= 1'b0;
        end else begin
            prev_reg <= rxLine;
            rc_reg <= rcInc;
            rxValid <= 1'b0;
            case (rs_reg)
                R_IDLE: begin
                    rc_reg <= 16'h0;
                    if (prev_reg && !rxLine) begin
                        rs_reg <= R_START;
                    end
                end
                R_START: begin
                    if (rHalf) begin
                        rs_reg <= rxLine ? R_IDLE : R_DATA;
                        rc_reg <= 16'h0;
                        rb_reg <= 4'h0;
                    end
                end
                R_DATA: begin
                    if (rTick) begin
                        rc_reg <= 16'h0;
                        rsh_reg <= {rxLine, rsh_reg[7:1]};
                        rb_reg <= rb_reg + 4'h1;
                        if (rb_reg == LBW_DATA_BITS - 4'h1) begin
                            rs_reg <= R_STOP;
                        end
                    end
                end
                R_STOP: begin
                    if (rTick) begin
                        rs_reg <= rxLine ? R_IDLE : R_WAITHI;
                        rxValid <= 1'b1;
                        rxData <= rsh_reg;
                        rxBreak <= !rxLine && rsh_reg == 8'h00;
                    end
                end
                default: begin
                    if (rxLine) begin
                        rs_reg <= R_IDLE;
                    end
                end
            endcase
        end
    end
endmodule : lbw_node
`default_nettype wire

// ==== tb/lbw_monitor.sv ====
`default_nettype none
module lbw_monitor #(
    parameter int BitCycles = 16,
    parameter int WakeBits = 13
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Serial lines
    input wire logic devTx,
    input wire logic nodeTx
);
    timeunit 1ns;
    timeprecision 1ns;
    ////////////////////////////////////////////////////////////////////////////
    // Run lengths of low and high levels
    int devLow_reg;
    int devHigh_reg;
    int nodeLow_reg;
    int nodeHigh_reg;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            devLow_reg <= 0;
            devHigh_reg <= 0;
            nodeLow_reg <= 0;
            nodeHigh_reg <= 0;
        end else begin
            devLow_reg <= devTx ? 0 : devLow_reg + 1;
            devHigh_reg <= devTx ? devHigh_reg + 1 : 0;
            nodeLow_reg <= nodeTx ? 0 : nodeLow_reg + 1;
            nodeHigh_reg <= nodeTx ? nodeHigh_reg + 1 : 0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Properties
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    sequence s_dev_low_bit;
        !devTx [*8];
    endsequence
    sequence s_node_low_bit;
        !nodeTx [*8];
    endsequence
    a_lines_idle_reset: assert property ($fell(rst) |-> devTx && nodeTx)
        else $error("line not idle after reset");
    a_dev_low_bit: assert property ($fell(devTx) |-> s_dev_low_bit)
        else $error("device low shorter than a bit");
    a_dev_high_bit: assert property ($rose(devTx) |-> devTx [*8])
        else $error("device high shorter than a bit");
    a_dev_bit_grid: assert property ($rose(devTx) |-> (devLow_reg % BitCycles) == 0)
        else $error("device low run off bit grid");
    a_dev_break_len: assert property ($rose(devTx) |-> devLow_reg <= 13 * BitCycles)
        else $error("device low run longer than a break");
    a_dev_stop_gap: assert property ($fell(devTx) |-> devHigh_reg >= BitCycles)
        else $error("device start without full stop");
    a_node_low_bit: assert property ($fell(nodeTx) |-> s_node_low_bit)
        else $error("node low shorter than a bit");
    a_node_wake_grid: assert property ($rose(nodeTx) |->
        (nodeLow_reg % BitCycles) == 0 && nodeLow_reg <= WakeBits * BitCycles)
        else $error("node low run off grid or too long");
    a_node_stop_gap: assert property ($fell(nodeTx) |-> nodeHigh_reg >= BitCycles)
        else $error("node start without idle gap");
endmodule : lbw_monitor
`default_nettype wire

// ==== tb/test_lin_break_wake_handler.sv ====
`default_nettype none
module test_lin_break_wake_handler import lbw_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BitCycles = 8;
    logic clock, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic wakeReq, headerReq, byteReq, busy, rxValid, rxBreak;
    logic [7:0] byteData, rxData;
    int miscompares, samples_checked;
    ////////////////////////////////////////////////////////////////////////////
    // Both ends and the monitor
    lbw_link_if link ();
    lbw_device #(.BitCycles(BitCycles)) u_lbw_device (.clock(clock), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link));
    lbw_node #(.BitCycles(BitCycles)) u_lbw_node (.clock(clock), .rst(rst), .wakeReq(wakeReq),
        .headerReq(headerReq), .byteReq(byteReq), .byteData(byteData), .busy(busy),
        .rxValid(rxValid), .rxData(rxData), .rxBreak(rxBreak), .link(link));
    lbw_monitor #(.BitCycles(BitCycles), .WakeBits(LBW_WAKE_BITS)) u_lbw_monitor (
        .clock(clock), .rst(rst), .devTx(link.devTx), .nodeTx(link.nodeTx));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task finish_test;
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test
    task hang(input string what);
        miscompares++;
        $display("wrong value %s expected done seen timeout", what);
        finish_test();
    endtask : hang
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) hang("bus answer");
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rd(input logic [11:0] a, input logic [31:0] exp, input string name);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(name, exp, r);
    endtask : rd
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task wait_idle;
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (busy !== 1'b0 && n < 3000);
        if (n >= 3000) hang("node busy");
    endtask : wait_idle
    task node_req(input logic [2:0] k, input logic [7:0] d, input bit w);
        @(posedge clock);
        wakeReq <= k[0];
        headerReq <= k[1];
        byteReq <= k[2];
        byteData <= d;
        @(posedge clock);
        wakeReq <= 1'b0;
        headerReq <= 1'b0;
        byteReq <= 1'b0;
        if (w) wait_idle();
    endtask : node_req
    task wait_rx(output logic [7:0] d, output logic b, output int n);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (rxValid !== 1'b1 && n < 3000);
        if (n >= 3000) hang("node receive");
        d = rxData;
        b = rxBreak;
    endtask : wait_rx
    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task scen_reset;
        logic [31:0] r;
        logic e;
        rd(LBW_OFF_CTRL, 32'h0, "ctrl reset");
        rd(LBW_OFF_STAT, 32'h38, "stat reset");
        apb(1'b0, 12'h010, 32'h0, r, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
    endtask : scen_reset
    task scen_break_sync;
        logic [7:0] d;
        logic b;
        int g;
        wr(LBW_OFF_CTRL, 32'h3);
        wr(LBW_OFF_TXD, 32'ha5);
        wr(LBW_OFF_TXD, {24'h0, LBW_SYNC_BYTE});
        rd(LBW_OFF_STAT, 32'h20, "stat during break");
        wait_rx(d, b, g);
        chk("break data", 32'h0, {24'h0, d});
        chk("break stop low", 32'h1, {31'h0, b});
        wait_rx(d, b, g);
        chk("sync data", {24'h0, LBW_SYNC_BYTE}, {24'h0, d});
        chk("sync stop", 32'h0, {31'h0, b});
        chk("sync gap", 32'h1, {31'h0, g >= 14 * BitCycles + 1 && g <= 14 * BitCycles + 2});
        rd(LBW_OFF_CTRL, 32'h1, "ctrl after break");
    endtask : scen_break_sync
    task scen_frame_break;
        node_req(3'b001, 8'h00, 1'b1);
        rd(LBW_OFF_STAT, 32'h3b, "stat after break");
        rd(LBW_OFF_RXD, 32'h0, "break byte");
        rd(LBW_OFF_STAT, 32'h38, "stat cleared");
    endtask : scen_frame_break
    task scen_wake;
        logic [31:0] r;
        logic e;
        int n;
        rd(LBW_OFF_STAT, 32'h38, "idle before wake");
        wr(LBW_OFF_CTRL, 32'hc);
        node_req(3'b010, 8'h00, 1'b0);
        n = 0;
        do begin
            apb(1'b0, LBW_OFF_STAT, 32'h0, r, e);
            n++;
        end while (r[LBW_ST_RXF] !== 1'b1 && n < 60);
        if (n >= 60) hang("wake flag");
        chk("wake flags", 32'h1, {30'h0, r[1:0]});
        rd(LBW_OFF_CTRL, 32'hc, "wake enable held");
        rd(LBW_OFF_RXD, 32'h0, "wake byte");
        wait_idle();
        rd(LBW_OFF_CTRL, 32'h8, "wake enable cleared");
        rd(LBW_OFF_STAT, 32'h39, "data flag");
        rd(LBW_OFF_RXD, {24'h0, LBW_SYNC_BYTE}, "data after wake");
    endtask : scen_wake
    task scen_short_wake;
        wr(LBW_OFF_CTRL, 32'h4);
        node_req(3'b100, 8'hf0, 1'b1);
        rd(LBW_OFF_CTRL, 32'h0, "short wake cleared");
        rd(LBW_OFF_STAT, 32'h39, "short wake flag");
        rd(LBW_OFF_RXD, 32'h0, "fragment byte");
    endtask : scen_short_wake
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        wakeReq = 1'b0;
        headerReq = 1'b0;
        byteReq = 1'b0;
        byteData = 8'h00;
        miscompares = 0;
        samples_checked = 0;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        scen_reset();
        scen_break_sync();
        scen_frame_break();
        scen_wake();
        scen_short_wake();
        finish_test();
    end
endmodule : test_lin_break_wake_handler
`default_nettype wire
